// >>> rtl/dfg_ctrl.v
// Diagnostic frame generator control: registers, burst/continuous sequencing,
// framing, payload mux and completion interrupt.
// Assumes a classic Wishbone master and a PHY byte-slot strobe on the same clock.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "dfg_defines.vh"
// What this block does
// RULE_01 - Continuous mode: frames forever, count ignored
// RULE_02 - Burst mode: exactly programmed count, then stop
// RULE_03 - Mode select resets to burst
// RULE_04 - Count is 32 bits, reloaded each start
// RULE_05 - Count resets to 256 frames
// RULE_06 - Payload length register, reset 0x6B
// RULE_07 - Frame adds addresses, length, check sequence
// RULE_08 - Gap bytes between frames, reset 0xC
// RULE_09 - Local enable gates completion interrupt
// RULE_10 - Software must also unmask subsystem bit
// RULE_11 - Completion latched in subsystem status register
// RULE_12 - Done flag latches high, read clears
// RULE_13 - Enabled generator feeds PHY, needs clock enable
// RULE_14 - Restart bit reloads count, self clears
// RULE_15 - Payload type selects data content
// RULE_16 - Captured count decrements per frame
module dfg_ctrl #(
  parameter [47:0] DEST_ADDR = 48'hFFFF_FFFF_FFFF,
  parameter [47:0] SRC_ADDR = 48'h0200_0000_0001
) (
  input wire I_SYS_CLK,
  input wire I_RSTN,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [17:0] I_WB_ADR,
  input wire [31:0] I_WB_DAT,
  input wire [3:0] I_WB_SEL,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK,
  input wire [7:0] I_MAC_TX_DATA,
  input wire I_MAC_TX_EN,
  input wire I_TX_BYTE_STROBE,
  output reg [7:0] O_TX_DATA,
  output reg O_TX_EN,
  output reg O_GEN_SELECT,
  output reg O_IRQ
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_HEAD = 3'd1;
  localparam [2:0] ST_DATA = 3'd2;
  localparam [2:0] ST_FCS = 3'd3;
  localparam [2:0] ST_GAP = 3'd4;

  reg gen_enable;
  reg diagnostic_clock_enable;
  reg [2:0] gen_payload_type;
  reg gen_continuous_select;
  reg gen_interrupt_enable;
  reg [15:0] gen_payload_length;
  reg [15:0] gen_gap_length;
  reg [15:0] gen_count_upper;
  reg [15:0] gen_count_lower;
  reg gen_completion_flag;
  reg check_gen_interrupt_latched;
  reg check_gen_interrupt_unmask;
  reg gen_restart;
  reg run_d;

  reg [2:0] state;
  reg [15:0] cnt;
  reg [31:0] left;
  reg [2:0] next_state;
  reg [15:0] next_cnt;
  reg [31:0] next_left;
  reg [7:0] tx_byte;
  reg tx_byte_en;
  reg crc_init;
  reg crc_en;
  reg pay_load;
  reg pay_step;
  reg finish;
  reg [31:0] rdata;
  reg next_flag;
  reg next_latched;

  wire [31:0] crc;
  wire [7:0] pay_data;
  wire [15:0] idx = I_WB_ADR[17:2];
  wire access = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire wr = access & I_WB_WE;
  wire rd = access & ~I_WB_WE;
  wire run = gen_enable & diagnostic_clock_enable; // [RULE_13]
  wire start = run & (~run_d | gen_restart); // [RULE_04] [RULE_14]
  wire [31:0] count_prog = {gen_count_upper, gen_count_lower}; // [RULE_04]
  wire [111:0] head_word = {DEST_ADDR, SRC_ADDR, gen_payload_length}; // [RULE_07]
  wire [6:0] head_base = 7'd111 - {cnt[3:0], 3'b000};
  wire [31:0] fcs = ~crc;
  wire [15:0] len_last = gen_payload_length - 16'h0001;
  wire [15:0] gap_last = gen_gap_length - 16'h0001;

  function [15:0] wr16;
    input [15:0] old;
    input [15:0] dat;
    input [1:0] sel;
    begin
      wr16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  dfg_crc32 u_crc (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .i_init(crc_init),
    .i_en(crc_en),
    .i_data(tx_byte),
    .o_crc(crc)
  );

  dfg_payload_gen u_payload (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .i_load(pay_load),
    .i_step(pay_step),
    .i_type(gen_payload_type),
    .o_data(pay_data)
  );

  // Sequencer; one byte per strobe while a frame is in flight
  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_left = left;
    tx_byte = 8'h00;
    tx_byte_en = 1'b0;
    crc_init = 1'b0;
    crc_en = 1'b0;
    pay_load = 1'b0;
    pay_step = 1'b0;
    finish = 1'b0;
    if (!run) begin
      next_state = ST_IDLE;
    end else if (start) begin
      next_cnt = 16'h0000;
      next_left = count_prog; // [RULE_16]
      crc_init = 1'b1;
      pay_load = 1'b1;
      if (!gen_continuous_select && count_prog == 32'h0000_0000) begin
        next_state = ST_IDLE;
        finish = 1'b1;
      end else begin
        next_state = ST_HEAD;
      end
    end else if (I_TX_BYTE_STROBE) begin
      case (state)
        ST_HEAD: begin
          tx_byte = head_word[head_base -: 8]; // [RULE_07]
          tx_byte_en = 1'b1;
          crc_en = 1'b1;
          next_cnt = cnt + 16'h0001;
          if (cnt[3:0] == `DFG_HEAD_LAST) begin
            next_cnt = 16'h0000;
            next_state = (gen_payload_length == 16'h0000) ? ST_FCS : ST_DATA;
          end
        end
        ST_DATA: begin
          tx_byte = pay_data; // [RULE_15]
          tx_byte_en = 1'b1;
          crc_en = 1'b1;
          pay_step = 1'b1;
          next_cnt = cnt + 16'h0001;
          if (cnt == len_last) begin // [RULE_06]
            next_cnt = 16'h0000;
            next_state = ST_FCS;
          end
        end
        ST_FCS: begin
          tx_byte = fcs[{cnt[1:0], 3'b000} +: 8]; // [RULE_07]
          tx_byte_en = 1'b1;
          next_cnt = cnt + 16'h0001;
          if (cnt[1:0] == `DFG_FCS_LAST) begin
            next_cnt = 16'h0000;
            if (!gen_continuous_select)
              next_left = left - 32'h0000_0001; // [RULE_16]
            if (gen_payload_type == `DFG_PTYPE_STOP) begin
              next_state = ST_IDLE; // [RULE_15]
            end else if (!gen_continuous_select && left == 32'h0000_0001) begin
              next_state = ST_IDLE; // [RULE_02]
              finish = 1'b1;
            end else if (gen_gap_length == 16'h0000) begin
              next_state = ST_HEAD; // [RULE_01]
              crc_init = 1'b1;
              pay_load = 1'b1;
            end else begin
              next_state = ST_GAP;
            end
          end
        end
        ST_GAP: begin
          next_cnt = cnt + 16'h0001;
          if (cnt == gap_last) begin // [RULE_08]
            next_cnt = 16'h0000;
            next_state = ST_HEAD;
            crc_init = 1'b1;
            pay_load = 1'b1;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Flag and interrupt updates: a completion in the read cycle wins
  always @* begin
    next_flag = gen_completion_flag;
    next_latched = check_gen_interrupt_latched;
    if (rd && idx == `DFG_IDX_DONE)
      next_flag = 1'b0;
    if (finish)
      next_flag = 1'b1; // [RULE_12]
    if (rd && idx == `DFG_IDX_SUB_STATUS)
      next_latched = 1'b0;
    if (finish && gen_interrupt_enable)
      next_latched = 1'b1; // [RULE_09] [RULE_11]
  end

  always @* begin
    rdata = 32'h0000_0000;
    case (idx)
      `DFG_IDX_ENABLE: rdata[0] = gen_enable;
      `DFG_IDX_CONTROL: rdata[`DFG_PTYPE_MSB:0] = gen_payload_type;
      `DFG_IDX_CONT_SELECT: rdata[0] = gen_continuous_select;
      `DFG_IDX_IRQ_ENABLE: rdata[0] = gen_interrupt_enable;
      `DFG_IDX_PAYLOAD_LEN: rdata[15:0] = gen_payload_length;
      `DFG_IDX_GAP_LEN: rdata[15:0] = gen_gap_length;
      `DFG_IDX_COUNT_UPPER: rdata[15:0] = gen_count_upper;
      `DFG_IDX_COUNT_LOWER: rdata[15:0] = gen_count_lower;
      `DFG_IDX_DONE: rdata[0] = gen_completion_flag; // [RULE_12]
      `DFG_IDX_STATUS: rdata[0] = (state != ST_IDLE);
      `DFG_IDX_DIAG_CLK: rdata[0] = diagnostic_clock_enable;
      `DFG_IDX_SUB_MASK: rdata[0] = check_gen_interrupt_unmask;
      `DFG_IDX_SUB_STATUS: rdata[0] = check_gen_interrupt_latched; // [RULE_11]
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Bus slave: ack one cycle after the strobe, unmapped reads return zero
  always @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= access;
      O_WB_DAT <= rd ? rdata : 32'h0000_0000;
    end
  end

  always @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      gen_enable <= 1'b0;
      diagnostic_clock_enable <= 1'b0;
      gen_payload_type <= `DFG_RST_CONTROL; // [RULE_15]
      gen_continuous_select <= `DFG_RST_CONT_SELECT; // [RULE_03]
      gen_interrupt_enable <= `DFG_RST_IRQ_ENABLE; // [RULE_09]
      gen_payload_length <= `DFG_RST_PAYLOAD_LEN; // [RULE_06]
      gen_gap_length <= `DFG_RST_GAP_LEN; // [RULE_08]
      gen_count_upper <= `DFG_RST_COUNT_UPPER; // [RULE_05]
      gen_count_lower <= `DFG_RST_COUNT_LOWER; // [RULE_05]
      check_gen_interrupt_unmask <= 1'b0;
      gen_restart <= 1'b0;
    end else begin
      // Restart is a pulse, so the bit always reads back zero
      gen_restart <= wr && idx == `DFG_IDX_CONTROL && I_WB_SEL[0]
        && I_WB_DAT[`DFG_BIT_RESTART]; // [RULE_14]
      if (wr) begin
        case (idx)
          `DFG_IDX_ENABLE: begin
            if (I_WB_SEL[0])
              gen_enable <= I_WB_DAT[0];
          end
          `DFG_IDX_CONTROL: begin
            if (I_WB_SEL[0])
              gen_payload_type <= I_WB_DAT[`DFG_PTYPE_MSB:0];
          end
          `DFG_IDX_CONT_SELECT: begin
            if (I_WB_SEL[0])
              gen_continuous_select <= I_WB_DAT[0];
          end
          `DFG_IDX_IRQ_ENABLE: begin
            if (I_WB_SEL[0])
              gen_interrupt_enable <= I_WB_DAT[0];
          end
          `DFG_IDX_PAYLOAD_LEN: begin
            gen_payload_length <= wr16(gen_payload_length, I_WB_DAT[15:0], I_WB_SEL[1:0]);
          end
          `DFG_IDX_GAP_LEN: begin
            gen_gap_length <= wr16(gen_gap_length, I_WB_DAT[15:0], I_WB_SEL[1:0]);
          end
          `DFG_IDX_COUNT_UPPER: begin
            gen_count_upper <= wr16(gen_count_upper, I_WB_DAT[15:0], I_WB_SEL[1:0]);
          end
          `DFG_IDX_COUNT_LOWER: begin
            gen_count_lower <= wr16(gen_count_lower, I_WB_DAT[15:0], I_WB_SEL[1:0]);
          end
          `DFG_IDX_DIAG_CLK: begin
            if (I_WB_SEL[0])
              diagnostic_clock_enable <= I_WB_DAT[0];
          end
          `DFG_IDX_SUB_MASK: begin
            if (I_WB_SEL[0])
              check_gen_interrupt_unmask <= I_WB_DAT[0]; // [RULE_10]
          end
          default: begin
            gen_restart <= 1'b0;
          end
        endcase
      end
    end
  end

  // Burst length is frozen in left, so mid-burst count writes wait for next start
  always @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      left <= 32'h0000_0000;
      run_d <= 1'b0;
      gen_completion_flag <= 1'b0;
      check_gen_interrupt_latched <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      left <= next_left; // [RULE_16]
      run_d <= run;
      gen_completion_flag <= next_flag; // [RULE_12]
      check_gen_interrupt_latched <= next_latched; // [RULE_11]
      O_IRQ <= next_latched & check_gen_interrupt_unmask; // [RULE_10]
    end
  end

  // PHY feed: MAC passes through unless the generator owns the line
  always @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      O_TX_DATA <= 8'h00;
      O_TX_EN <= 1'b0;
      O_GEN_SELECT <= 1'b0;
    end else begin
      O_GEN_SELECT <= run; // [RULE_13]
      if (!run) begin
        O_TX_DATA <= I_MAC_TX_DATA;
        O_TX_EN <= I_MAC_TX_EN;
      end else if (I_TX_BYTE_STROBE || start) begin
        O_TX_DATA <= tx_byte; // [RULE_13]
        O_TX_EN <= tx_byte_en;
      end
    end
  end
endmodule // dfg_ctrl

// >>> rtl/dfg_defines.vh
// Register indices, field positions, reset values and framing counts of the
// diagnostic frame generator. Byte address on the bus is four times the index.
`ifndef DFG_DEFINES_VH
`define DFG_DEFINES_VH

`define DFG_IDX_ENABLE 16'h8020
`define DFG_IDX_CONTROL 16'h8021
`define DFG_IDX_CONT_SELECT 16'h8022
`define DFG_IDX_IRQ_ENABLE 16'h8023
`define DFG_IDX_PAYLOAD_LEN 16'h8025
`define DFG_IDX_GAP_LEN 16'h8026
`define DFG_IDX_COUNT_UPPER 16'h8027
`define DFG_IDX_COUNT_LOWER 16'h8028
`define DFG_IDX_DONE 16'h8029
`define DFG_IDX_STATUS 16'h802A
`define DFG_IDX_DIAG_CLK 16'h8030
`define DFG_IDX_SUB_MASK 16'h8031
`define DFG_IDX_SUB_STATUS 16'h8032

`define DFG_BIT_RESTART 3
`define DFG_PTYPE_MSB 2

`define DFG_RST_CONTROL 3'h1
`define DFG_RST_CONT_SELECT 1'b0
`define DFG_RST_IRQ_ENABLE 1'b0
`define DFG_RST_PAYLOAD_LEN 16'h006B
`define DFG_RST_GAP_LEN 16'h000C
`define DFG_RST_COUNT_UPPER 16'h0000
`define DFG_RST_COUNT_LOWER 16'h0100

`define DFG_PTYPE_STOP 3'h0
`define DFG_PTYPE_RANDOM 3'h1
`define DFG_PTYPE_ZEROS 3'h2
`define DFG_PTYPE_ONES 3'h3
`define DFG_PTYPE_ALT55 3'h4
`define DFG_PTYPE_DECR 3'h5

`define DFG_HEAD_LAST 4'hD
`define DFG_FCS_LAST 2'h3
`define DFG_CRC_INIT 32'hFFFF_FFFF
`define DFG_CRC_POLY 32'hEDB8_8320
`define DFG_LFSR_SEED 16'hACE1
`define DFG_LFSR_TAPS 16'hB400
`define DFG_DECR_START 8'hFF
`define DFG_ALT_BYTE 8'h55

`endif

// >>> rtl/dfg_crc32.v
// Running frame check sequence over transmitted bytes, reflected, LSB first.
// Assumes init and update never arrive in the same cycle.
`timescale 1ns/1ps
`include "dfg_defines.vh"
module dfg_crc32 (
  input wire i_clk,
  input wire i_rstn,
  input wire i_init,
  input wire i_en,
  input wire [7:0] i_data,
  output reg [31:0] o_crc
);
  function [31:0] crc_step;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ `DFG_CRC_POLY;
        else
          r = r >> 1;
      end
      crc_step = r;
    end
  endfunction

  always @(posedge i_clk) begin
    if (!i_rstn)
      o_crc <= `DFG_CRC_INIT;
    else if (i_init)
      o_crc <= `DFG_CRC_INIT;
    else if (i_en)
      o_crc <= crc_step(o_crc, i_data);
  end
endmodule // dfg_crc32

// >>> rtl/dfg_payload_gen.v
// Payload byte source: holds the byte to send next in a register.
// Assumes i_load at frame start and i_step once per payload byte taken.
`timescale 1ns/1ps
`include "dfg_defines.vh"
module dfg_payload_gen (
  input wire i_clk,
  input wire i_rstn,
  input wire i_load,
  input wire i_step,
  input wire [2:0] i_type,
  output reg [7:0] o_data
);
  reg [15:0] lfsr;
  reg [7:0] down;
  reg [15:0] next_lfsr;
  reg [7:0] next_down;

  function [7:0] pick;
    input [2:0] t;
    input [7:0] rnd;
    input [7:0] dec;
    begin
      case (t)
        `DFG_PTYPE_RANDOM: pick = rnd;
        `DFG_PTYPE_ONES: pick = 8'hFF;
        `DFG_PTYPE_ALT55: pick = `DFG_ALT_BYTE;
        `DFG_PTYPE_DECR: pick = dec;
        default: pick = 8'h00;
      endcase
    end
  endfunction

  always @* begin
    next_lfsr = lfsr;
    next_down = down;
    if (i_step)
      next_lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `DFG_LFSR_TAPS : 16'h0000);
    if (i_load)
      next_down = `DFG_DECR_START;
    else if (i_step)
      next_down = down - 8'h01;
  end

  // Random stream is not reseeded per frame, so frames differ
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      lfsr <= `DFG_LFSR_SEED;
      down <= `DFG_DECR_START;
      o_data <= 8'h00;
    end else begin
      lfsr <= next_lfsr;
      down <= next_down;
      o_data <= pick(i_type, next_lfsr[7:0], next_down);
    end
  end
endmodule // dfg_payload_gen

// >>> test/dfg_ctrl_asserts.sv
// Checker for dfg_ctrl: bus answer, pass-through, byte hold and interrupt clear.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module dfg_ctrl_asserts (
  input wire I_SYS_CLK,
  input wire I_RSTN,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [17:0] I_WB_ADR,
  input wire [31:0] O_WB_DAT,
  input wire O_WB_ACK,
  input wire [7:0] I_MAC_TX_DATA,
  input wire I_MAC_TX_EN,
  input wire I_TX_BYTE_STROBE,
  input wire [7:0] O_TX_DATA,
  input wire O_TX_EN,
  input wire O_GEN_SELECT,
  input wire O_IRQ
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);
  sequence s_req;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence s_rd(idx);
    s_req ##0 (!I_WB_WE && I_WB_ADR[17:2] == idx);
  endsequence
  property p_ack_answer;
    s_req |=> O_WB_ACK;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_ack_pulse;
    O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle;
    !O_WB_ACK |-> O_WB_DAT == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_done_bits;
    s_rd(16'h8029) |=> O_WB_DAT[31:1] == 31'h0000_0000;
  endproperty
  a_done_bits: assert property (p_done_bits) else $error("done upper bits");
  // Status and the level output are both cleared at the same read edge
  property p_irq_clear;
    s_rd(16'h8032) ##0 O_IRQ |-> ##[1:2] !O_IRQ;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
  property p_mac_pass;
    !O_GEN_SELECT [*3] |-> O_TX_EN == $past(I_MAC_TX_EN) && O_TX_DATA == $past(I_MAC_TX_DATA);
  endproperty
  a_mac_pass: assert property (p_mac_pass) else $error("mac not passed");
  property p_gen_hold;
    O_GEN_SELECT [*3] ##0 !$past(I_TX_BYTE_STROBE) |-> $stable(O_TX_EN) && $stable(O_TX_DATA);
  endproperty
  a_gen_hold: assert property (p_gen_hold) else $error("byte without slot");
  property p_reset_quiet;
    $rose(I_RSTN) |-> !O_IRQ && !O_GEN_SELECT && !O_TX_EN && !O_WB_ACK;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
endmodule // dfg_ctrl_asserts
bind dfg_ctrl dfg_ctrl_asserts chk (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .I_MAC_TX_DATA(I_MAC_TX_DATA), .I_MAC_TX_EN(I_MAC_TX_EN),
  .I_TX_BYTE_STROBE(I_TX_BYTE_STROBE), .O_TX_DATA(O_TX_DATA), .O_TX_EN(O_TX_EN),
  .O_GEN_SELECT(O_GEN_SELECT), .O_IRQ(O_IRQ));

// >>> test/dfg_phy_model.sv
// PHY transmit side: byte-slot strobes at a set spacing; measures frames and gaps.
// Assumes the block updates its byte in the cycle after each strobe.
`timescale 1ns/1ps
module dfg_phy_model (
  input wire i_clk,
  input wire i_rstn,
  input wire [1:0] i_space,
  input wire [7:0] i_tx_data,
  input wire i_tx_en,
  output reg o_strobe,
  output reg o_rep,
  output reg [15:0] o_len,
  output reg [15:0] o_gap,
  output reg [15:0] o_hdr,
  output reg [15:0] o_pay,
  output reg [31:0] o_res
);
  reg [1:0] div;
  reg take;
  reg [15:0] n;
  reg [15:0] g;
  reg [31:0] c;
  // Reflected CRC-32 over every byte, check sequence included, so a good frame ends at the residue
  function automatic logic [31:0] crc_next(input logic [31:0] s, input logic [7:0] d);
    crc_next = s;
    for (int i = 0; i < 8; i++)
      crc_next = (crc_next >> 1) ^ ((crc_next[0] ^ d[i]) ? 32'hedb8_8320 : 32'h0000_0000);
  endfunction
  always @(posedge i_clk) begin
    o_rep <= 1'b0;
    if (!i_rstn) begin
      div <= 2'h0;
      o_strobe <= 1'b0;
      take <= 1'b0;
      n <= 16'h0000;
      g <= 16'h0000;
    end else begin
      // Spacing 0 keeps the strobe high: every cycle is a slot
      o_strobe <= (div == 2'h0);
      div <= (div == i_space) ? 2'h0 : div + 2'h1;
      take <= o_strobe;
      if (take && i_tx_en) begin
        n <= n + 16'h0001;
        c <= crc_next((n == 16'h0000) ? 32'hffff_ffff : c, i_tx_data);
        if (n == 16'h0000) o_gap <= g;
        if (n == 16'h000c) o_hdr[15:8] <= i_tx_data;
        if (n == 16'h000d) o_hdr[7:0] <= i_tx_data;
        if (n == 16'h000e) o_pay[15:8] <= i_tx_data;
        if (n == 16'h000f) o_pay[7:0] <= i_tx_data;
      end else if (take) begin
        g <= (n == 16'h0000) ? g + 16'h0001 : 16'h0001;
        o_rep <= (n != 16'h0000);
        o_len <= n;
        o_res <= c;
        n <= 16'h0000;
      end
    end
  end
endmodule // dfg_phy_model

// >>> test/dfg_ctrl_bench.sv
// Bench for dfg_ctrl: registers, bursts, continuous mode, payload types, interrupt.
// Assumes dfg_phy_model on the PHY side and the bound checker.
`timescale 1ns/1ps
module dfg_ctrl_bench;
  logic clk, rstn, cyc, stb, we, mac_en, mac_on, ack, strobe, txen, gsel, irq, rep, ign;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, fres;
  logic [31:0] lfsr = 32'hb5a9_2bf3;
  logic [7:0] mac_dat, txd;
  logic [1:0] space;
  logic [15:0] flen, fgap, fhdr, fpay, v;
  logic [16:0] rq[$];
  logic [65:0] fq[$];
  logic [15:0] ptab[6] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h5555, 16'hfffe};
  logic [15:0] ridx[9] = '{16'h8021, 16'h8022, 16'h8023, 16'h8024, 16'h8025, 16'h8026,
                           16'h8027, 16'h8028, 16'h8029};
  logic [15:0] rrst[9] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h006b, 16'h000c,
                           16'h0000, 16'h0100, 16'h0000};
  int failures, n_checks, n;
  dfg_ctrl dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(4'hf), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_MAC_TX_DATA(mac_dat), .I_MAC_TX_EN(mac_en), .I_TX_BYTE_STROBE(strobe),
    .O_TX_DATA(txd), .O_TX_EN(txen), .O_GEN_SELECT(gsel), .O_IRQ(irq));
  dfg_phy_model phy (.i_clk(clk), .i_rstn(rstn), .i_space(space), .i_tx_data(txd),
    .i_tx_en(txen), .o_strobe(strobe), .o_rep(rep), .o_len(flen), .o_gap(fgap),
    .o_hdr(fhdr), .o_pay(fpay), .o_res(fres));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("failures=%0d n_checks=%0d", failures, n_checks);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Every access leaves a note; reads are compared when ack shows
  task automatic wb(input logic w, input logic [15:0] i, input logic [15:0] d,
                    input logic [15:0] e);
    rq.push_back({!w, e});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {16'h0000, d};
    for (n = 0; n < 40 && ack !== 1'b1; n++) @(posedge clk);
    if (n >= 40) begin
      failures++;
      end_sim;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    wb(1'b1, i, d, 16'h0000);
  endtask
  task automatic rd(input logic [15:0] i, input logic [15:0] e);
    wb(1'b0, i, 16'h0000, e);
  endtask
  task automatic cfg(input logic [15:0] l, input logic [15:0] g, input logic [15:0] c,
                     input logic [2:0] t);
    wr(16'h8025, l);
    wr(16'h8026, g);
    wr(16'h8027, 16'h0000);
    wr(16'h8028, c);
    wr(16'h8021, {13'h0000, t});
  endtask
  task automatic note(input logic [15:0] l, input logic [15:0] g, input logic [2:0] t,
                      input logic first);
    fq.push_back({first, t < 3'h2, l + 16'h0012, g, l, ptab[t]});
  endtask
  task automatic drain(input int idle);
    for (n = 0; n < 5000 && fq.size() > 0; n++) @(posedge clk);
    if (n >= 5000) begin
      failures++;
      end_sim;
    end
    repeat (idle) @(posedge clk);
  endtask
  always @(posedge clk) begin
    lfsr <= nxt(lfsr);
    mac_dat <= lfsr[7:0];
    mac_en <= mac_on & lfsr[8];
  end
  always @(posedge clk) begin
    if (ack === 1'b1 && rq.size() > 0) begin
      if (rq[0][16]) check(rdat[15:0], rq[0][15:0]);
      rq.delete(0);
    end
    if (rep === 1'b1 && !ign) begin
      if (fq.size() == 0) check(flen, 16'h0000);
      else begin
        check(flen, fq[0][63:48]);
        check(fhdr, fq[0][31:16]);
        check(fres[31:16], 16'hdebb);
        check(fres[15:0], 16'h20e3);
        if (!fq[0][65]) check(fgap, fq[0][47:32]);
        if (!fq[0][64]) check(fpay, fq[0][15:0]);
        fq.delete(0);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    // Run needs a few thousand cycles; this leaves ample margin
    #60000;
    failures++;
    end_sim;
  end
  initial begin
    {rstn, cyc, stb, we, mac_on, ign} = 6'h00;
    adr = 18'h0_0000;
    wdat = 32'h0000_0000;
    space = 2'h1;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(16'h8024, 16'hffff);
    foreach (ridx[i]) rd(ridx[i], rrst[i]);
    for (int i = 4; i < 8; i++) begin
      v = lfsr[15:0];
      wr(ridx[i], v);
      rd(ridx[i], v);
    end
    wr(16'h8022, 16'hffff);
    rd(16'h8022, 16'h0001);
    wr(16'h8022, 16'h0000);
    wr(16'h8030, 16'h0001);
    wr(16'h8031, 16'h0001);
    wr(16'h8023, 16'h0001);
    cfg(16'h0004, 16'h0003, 16'h0003, 3'h2);
    for (int k = 0; k < 3; k++) note(16'h0004, 16'h0003, 3'h2, k == 0);
    wr(16'h8020, 16'h0001);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    check({15'h0000, irq}, 16'h0001);
    rd(16'h8029, 16'h0001);
    rd(16'h8029, 16'h0000);
    rd(16'h8032, 16'h0001);
    rd(16'h8032, 16'h0000);
    drain(80);
    check({15'h0000, irq}, 16'h0000);
    check(16'(fq.size()), 16'h0000);
    // Count of one, yet three frames must come out
    wr(16'h8020, 16'h0000);
    space <= 2'h2;
    wr(16'h8022, 16'h0001);
    cfg(16'h0003, 16'h0002, 16'h0001, 3'h3);
    for (int k = 0; k < 3; k++) note(16'h0003, 16'h0002, 3'h3, k == 0);
    wr(16'h8020, 16'h0001);
    drain(0);
    ign <= 1'b1;
    wr(16'h8020, 16'h0000);
    rd(16'h8029, 16'h0000);
    mac_on <= 1'b1;
    repeat (60) @(posedge clk);
    mac_on <= 1'b0;
    wr(16'h8022, 16'h0000);
    wr(16'h8023, 16'h0000);
    wr(16'h8028, 16'h0000);
    wr(16'h8020, 16'h0001);
    rd(16'h8029, 16'h0001);
    repeat (40) @(posedge clk);
    ign <= 1'b0;
    for (int t = 0; t < 6; t++) begin
      space <= t[1:0];
      cfg(16'(t + 2), 16'(t + 1), 16'h0002, t[2:0]);
      for (int k = 0; k < 2 - (t == 0); k++) note(16'(t + 2), 16'(t + 1), t[2:0], k == 0);
      wr(16'h8021, {12'h000, 1'b1, t[2:0]});
      rd(16'h8021, {13'h0000, t[2:0]});
      drain(80);
      rd(16'h8029, {15'h0000, t != 0});
      rd(16'h8032, 16'h0000);
    end
    // Reset in mid-frame: outputs must drop and registers return to reset values
    wr(16'h8021, 16'h000b);
    ign <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(16'h8020, 16'h0000);
    rd(16'h8021, 16'h0001);
    rd(16'h8028, 16'h0100);
    end_sim;
  end
endmodule // dfg_ctrl_bench
